/* hw/hub_desc_builder.v */
/*
 * Class-specific hub descriptor builder. Holds the configuration that
 * shapes the descriptor in APB registers and streams the descriptor
 * bytes out on a ready/valid byte port when a get-hub-descriptor
 * request arrives.
 * Assumes a single 100 MHz clock, synchronous active-low reset, an APB
 * master following the usual setup/access protocol and a request
 * source that pulses REQ_VALID for one cycle per request.
 */
`timescale 1ns/10ps
`default_nettype none
`include "hub_desc_defs.vh"

// Summary of operation
// [R1] Answer descriptor types 29h and 00h only
// [R2] Byte 0 is 09h, byte 1 is 29h
// [R3] Byte 2 carries downstream port count
// [R4] Port count is three minus disabled ports
// [R5] Power source select picks disable mask
// [R6] Bits 1:0 follow port power switching
// [R7] Bit 2 compound, bits 4:3 overcurrent sensing
// [R8] Bits 6:5 zero for 8FS think time
// [R9] Bit 7 zero, upper byte zero
// [R10] Byte 5 is power-on time, 2 ms
// [R11] Byte 6 controller current follows power source
// [R12] Characteristics LSB first; truncate to request length
module hub_desc_builder (
    input wire CLK,
    input wire RST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire REQ_VALID,
    input wire [7:0] REQ_TYPE,
    input wire [15:0] REQ_LEN,
    output reg REQ_DONE,
    output reg REQ_STALL,
    output reg TX_VALID,
    output reg [7:0] TX_DATA,
    output reg TX_LAST,
    input wire TX_READY
);

    // ============================================================
    // State and declarations
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    reg [31:0] cfg_ff;
    reg [31:0] pwr_ff;
    reg state_ff;
    reg nxt_state;
    reg [3:0] idx_ff;
    reg [3:0] nxt_idx;
    reg [3:0] end_ff;
    reg [3:0] nxt_end;
    reg [3:0] req_end;
    reg nxt_valid;
    reg [7:0] nxt_data;
    reg nxt_last;
    reg nxt_done;
    reg nxt_stall;
    reg [31:0] nxt_prdata;
    reg nxt_pready;
    reg nxt_pslverr;

    wire power_source_select;
    wire port_power_switching_cfg;
    wire compound_cfg;
    wire [1:0] overcurrent_sensing_cfg;
    wire [2:0] bus_powered_port_disable_mask;
    wire [2:0] self_powered_port_disable_mask;
    wire [2:0] active_mask;
    wire [7:0] port_count;
    wire [15:0] characteristics;
    wire [7:0] hc_current;
    wire apb_access;
    wire apb_commit;
    wire addr_mapped;
    wire type_ok;

    // ============================================================
    // Functions
    function [1:0] ones3;
        input [2:0] m;
        begin
            ones3 = {1'b0, m[0]} + {1'b0, m[1]} + {1'b0, m[2]};
        end
    endfunction

    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `ADDR_CFG) || (a == `ADDR_PWR) ||
                (a == `ADDR_STATUS);
        end
    endfunction

    function [7:0] desc_byte;
        input [3:0] i;
        input [7:0] nports;
        input [15:0] chr;
        input [7:0] pwr_on;
        input [7:0] hc_cur;
        input [7:0] removable;
        begin
            case (i)
                `IDX_LEN: desc_byte = `DESC_LEN; // [R2]
                `IDX_TYPE: desc_byte = `DESC_TYPE_HUB; // [R2]
                `IDX_NPORTS: desc_byte = nports; // [R3]
                `IDX_CHAR_LO: desc_byte = chr[7:0]; // [R12]
                `IDX_CHAR_HI: desc_byte = chr[15:8]; // [R12]
                `IDX_PWR_ON: desc_byte = pwr_on; // [R10]
                `IDX_HC_CUR: desc_byte = hc_cur; // [R11]
                `IDX_REMOVABLE: desc_byte = removable;
                default: desc_byte = `DESC_LEGACY_MASK;
            endcase
        end
    endfunction

    // ============================================================
    // Configuration fields and derived descriptor values
    assign power_source_select = cfg_ff[`CFG_PSRC];
    assign port_power_switching_cfg = cfg_ff[`CFG_PPSW];
    assign compound_cfg = cfg_ff[`CFG_COMPOUND];
    assign overcurrent_sensing_cfg = cfg_ff[`CFG_OCS_HI:`CFG_OCS_LO];
    assign bus_powered_port_disable_mask =
        cfg_ff[`CFG_BPMASK_HI:`CFG_BPMASK_LO];
    assign self_powered_port_disable_mask =
        cfg_ff[`CFG_SPMASK_HI:`CFG_SPMASK_LO];

    // Mask and current track the live mode, so a mode change between
    // requests is reflected in the next descriptor
    assign active_mask = power_source_select ?
        self_powered_port_disable_mask :
        bus_powered_port_disable_mask; // [R5]
    assign port_count = {6'h00,
        `DESC_TOTAL_PORTS - ones3(active_mask)}; // [R4]
    assign hc_current = power_source_select ?
        pwr_ff[`PWR_HCSP_HI:`PWR_HCSP_LO] :
        pwr_ff[`PWR_HCBP_HI:`PWR_HCBP_LO]; // [R11]

    assign characteristics = {
        `CHAR_UPPER, // [R9]
        `CHAR_NO_IND, // [R9]
        `CHAR_TT_8FS, // [R8]
        overcurrent_sensing_cfg, // [R7]
        compound_cfg, // [R7]
        port_power_switching_cfg ? `CHAR_PWR_INDIV :
            `CHAR_PWR_GANGED // [R6]
    };

    // ============================================================
    // APB slave: one wait state, so every access phase is two cycles
    assign apb_access = PSEL && PENABLE;
    assign apb_commit = apb_access && PREADY;
    assign addr_mapped = is_mapped(PADDR);

    always @*
    begin
        nxt_pready = apb_access && !PREADY;
        nxt_pslverr = apb_access && !PREADY && !addr_mapped;
        nxt_prdata = `ZERO32;
        if (apb_access && !PREADY && !PWRITE)
        begin
            case (PADDR)
                `ADDR_CFG: nxt_prdata = cfg_ff;
                `ADDR_PWR: nxt_prdata = pwr_ff;
                `ADDR_STATUS: nxt_prdata = {7'h00, state_ff,
                    characteristics, port_count};
                default: nxt_prdata = `ZERO32;
            endcase
        end
    end

    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            cfg_ff <= `RST_CFG;
            pwr_ff <= `RST_PWR;
            PRDATA <= `ZERO32;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PRDATA <= nxt_prdata;
            PREADY <= nxt_pready;
            PSLVERR <= nxt_pslverr;
            // Writes land only at the edge that completes the transfer
            if (apb_commit && PWRITE && PADDR == `ADDR_CFG)
                cfg_ff <= PWDATA & `CFG_WMASK;
            if (apb_commit && PWRITE && PADDR == `ADDR_PWR)
                pwr_ff <= PWDATA;
        end
    end

    // ============================================================
    // Descriptor request and byte stream
    assign type_ok = (REQ_TYPE == `DESC_TYPE_HUB) ||
        (REQ_TYPE == `DESC_TYPE_LEGACY); // [R1]

    always @*
    begin
        if (REQ_LEN >= `DESC_LEN_FULL)
            req_end = `DESC_LAST_IDX;
        else
            req_end = REQ_LEN[3:0] - 4'h1; // [R12]
    end

    always @*
    begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_end = end_ff;
        nxt_valid = TX_VALID;
        nxt_data = TX_DATA;
        nxt_last = TX_LAST;
        nxt_done = 1'b0;
        nxt_stall = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                if (REQ_VALID && !type_ok)
                    nxt_stall = 1'b1; // [R1]
                else if (REQ_VALID && REQ_LEN == 16'h0000)
                    nxt_done = 1'b1;
                else if (REQ_VALID)
                begin
                    nxt_state = ST_SEND;
                    nxt_idx = `IDX_LEN;
                    nxt_end = req_end; // [R12]
                    nxt_valid = 1'b1;
                    nxt_last = (req_end == `IDX_LEN);
                    nxt_data = desc_byte(`IDX_LEN, port_count,
                        characteristics, pwr_ff[`PWR_ON_HI:`PWR_ON_LO],
                        hc_current, pwr_ff[`PWR_REM_HI:`PWR_REM_LO]);
                end
            end
            ST_SEND:
            begin
                // A request arriving mid-stream is refused, not queued
                if (REQ_VALID)
                    nxt_stall = 1'b1;
                if (TX_READY)
                begin
                    if (idx_ff == end_ff)
                    begin
                        nxt_state = ST_IDLE;
                        nxt_valid = 1'b0;
                        nxt_last = 1'b0;
                        nxt_done = 1'b1;
                    end
                    else
                    begin
                        nxt_idx = idx_ff + 4'h1;
                        nxt_last = (nxt_idx == end_ff); // [R12]
                        nxt_data = desc_byte(nxt_idx, port_count,
                            characteristics,
                            pwr_ff[`PWR_ON_HI:`PWR_ON_LO], hc_current,
                            pwr_ff[`PWR_REM_HI:`PWR_REM_LO]);
                    end
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_valid = 1'b0;
                nxt_last = 1'b0;
            end
        endcase
    end

    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state_ff <= ST_IDLE;
            idx_ff <= `IDX_LEN;
            end_ff <= `IDX_LEN;
            TX_VALID <= 1'b0;
            TX_DATA <= `CHAR_UPPER;
            TX_LAST <= 1'b0;
            REQ_DONE <= 1'b0;
            REQ_STALL <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            end_ff <= nxt_end;
            TX_VALID <= nxt_valid;
            TX_DATA <= nxt_data;
            TX_LAST <= nxt_last;
            REQ_DONE <= nxt_done;
            REQ_STALL <= nxt_stall;
        end
    end

endmodule
`default_nettype wire

/* hw/hub_desc_defs.vh */
/*
 * Constants for the class-specific hub descriptor builder: descriptor
 * bytes, request type codes, register offsets, field positions and
 * reset values of the configuration registers.
 * Assumes inclusion by bare name from the builder module only.
 */
`ifndef HUB_DESC_DEFS_VH
`define HUB_DESC_DEFS_VH

// ============================================================
// Descriptor constants
`define DESC_LEN 8'h09
`define DESC_TYPE_HUB 8'h29
`define DESC_TYPE_LEGACY 8'h00
`define DESC_LEGACY_MASK 8'hff
`define DESC_TOTAL_PORTS 2'h3
`define DESC_LAST_IDX 4'h8
`define DESC_LEN_FULL 16'h0009

// Byte offsets within the descriptor
`define IDX_LEN 4'h0
`define IDX_TYPE 4'h1
`define IDX_NPORTS 4'h2
`define IDX_CHAR_LO 4'h3
`define IDX_CHAR_HI 4'h4
`define IDX_PWR_ON 4'h5
`define IDX_HC_CUR 4'h6
`define IDX_REMOVABLE 4'h7

// Characteristics word constants
`define CHAR_PWR_GANGED 2'h0
`define CHAR_PWR_INDIV 2'h1
`define CHAR_TT_8FS 2'h0
`define CHAR_NO_IND 1'h0
`define CHAR_UPPER 8'h00

// ============================================================
// Register byte offsets (APB, one aligned word each)
`define ADDR_CFG 12'h000
`define ADDR_PWR 12'h004
`define ADDR_STATUS 12'h008

// CFG fields
`define CFG_PSRC 0
`define CFG_PPSW 1
`define CFG_COMPOUND 2
`define CFG_OCS_LO 3
`define CFG_OCS_HI 4
`define CFG_BPMASK_LO 8
`define CFG_BPMASK_HI 10
`define CFG_SPMASK_LO 12
`define CFG_SPMASK_HI 14

// PWR fields
`define PWR_ON_LO 0
`define PWR_ON_HI 7
`define PWR_HCBP_LO 8
`define PWR_HCBP_HI 15
`define PWR_HCSP_LO 16
`define PWR_HCSP_HI 23
`define PWR_REM_LO 24
`define PWR_REM_HI 31

// Reset values, CFG write mask and zero word
`define RST_CFG 32'h0000_0001
`define RST_PWR 32'h0001_0132
`define CFG_WMASK 32'h0000_771f
`define ZERO32 32'h0000_0000

`endif

/* testbench/hub_desc_props.sv */
/* Checker for the hub descriptor builder's request and byte ports.
   Assumes one clock domain and is bound to the builder's top ports. */
`timescale 1ns/10ps
`default_nettype none
module hub_desc_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire logic [7:0] REQ_TYPE,
    input wire logic [15:0] REQ_LEN,
    input wire logic REQ_DONE,
    input wire logic REQ_STALL,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_LAST,
    input wire logic TX_READY
);
    // ====================
    // Byte position tracker
    logic [3:0] idx_ff;
    logic [3:0] last_ff;
    logic ok_t;
    assign ok_t = REQ_TYPE == 8'h29 || REQ_TYPE == 8'h00;
    always @(posedge CLK)
    begin
        if (!RST_N || !TX_VALID)
            idx_ff <= 4'h0;
        else if (TX_READY)
            idx_ff <= idx_ff + 4'h1;
        // Only an idle request can start a stream
        if (REQ_VALID && !TX_VALID)
            last_ff <= REQ_LEN > 16'h0008 ? 4'h8 : REQ_LEN[3:0] - 4'h1;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // ====================
    // Properties
    property p_take; REQ_VALID && !TX_VALID && ok_t && REQ_LEN != 16'h0000
        |=> TX_VALID && !REQ_STALL; endproperty
    a_take: assert property (p_take) else $error("no start");
    property p_bad; REQ_VALID && !ok_t |=> REQ_STALL && !REQ_DONE;
    endproperty
    a_bad: assert property (p_bad) else $error("no refusal");
    property p_busy; REQ_VALID && TX_VALID |=> REQ_STALL; endproperty
    a_busy: assert property (p_busy) else $error("busy taken");
    property p_b0; TX_VALID && idx_ff == 4'h0 |-> TX_DATA == 8'h09;
    endproperty
    a_b0: assert property (p_b0) else $error("byte 0");
    property p_b1; TX_VALID && idx_ff == 4'h1 |-> TX_DATA == 8'h29;
    endproperty
    a_b1: assert property (p_b1) else $error("byte 1");
    property p_np; TX_VALID && idx_ff == 4'h2 |-> TX_DATA <= 8'h03;
    endproperty
    a_np: assert property (p_np) else $error("port count");
    property p_clo; TX_VALID && idx_ff == 4'h3
        |-> TX_DATA[7:5] == 3'h0 && !TX_DATA[1]; endproperty
    a_clo: assert property (p_clo) else $error("char low");
    property p_chi; TX_VALID && idx_ff == 4'h4 |-> TX_DATA == 8'h00;
    endproperty
    a_chi: assert property (p_chi) else $error("char high");
    property p_last; TX_VALID |-> TX_LAST == (idx_ff == last_ff);
    endproperty
    a_last: assert property (p_last) else $error("length");
    property p_done; TX_VALID && TX_READY && TX_LAST
        |=> REQ_DONE && !TX_VALID; endproperty
    a_done: assert property (p_done) else $error("no done");
    c_stall: cover property (REQ_STALL);
    c_done: cover property (REQ_DONE);
    c_wait: cover property (TX_VALID && TX_LAST && !TX_READY);
endmodule
bind hub_desc_builder hub_desc_props i_hub_desc_props (
    .CLK(CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_TYPE(REQ_TYPE),
    .REQ_LEN(REQ_LEN), .REQ_DONE(REQ_DONE), .REQ_STALL(REQ_STALL),
    .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST),
    .TX_READY(TX_READY));
`default_nettype wire

/* testbench/hub_host_model.sv */
/* Host side model: takes descriptor bytes and keeps them in order.
   Assumes the builder's ready/valid byte port on the same clock. */
`timescale 1ns/10ps
`default_nettype none
module hub_host_model (
    input wire logic clk,
    input wire logic clr,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] got [0:15];
    logic ph_ff = 1'b0;
    int n = 0;
    // Slow mode stalls every other cycle so holds are exercised
    assign tx_ready = !slow || ph_ff;
    always @(posedge clk)
    begin
        ph_ff <= !ph_ff;
        if (clr)
            n <= 0;
        else if (tx_valid && tx_ready)
        begin
            got[n[3:0]] <= tx_data;
            n <= n + 1;
        end
    end
endmodule
`default_nettype wire

/* testbench/tb_hub_desc_builder.sv */
/* Bench for the hub descriptor builder: registers over APB, a table of
   descriptor requests, then refusals. Assumes the host model. */
`timescale 1ns/10ps
`default_nettype none
module tb_hub_desc_builder;
    typedef struct packed {logic [31:0] cfg; logic [31:0] pwr;
        logic [7:0] typ; logic [15:0] len; logic [7:0] np;} row_t;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic REQ_VALID = 1'b0;
    logic [7:0] REQ_TYPE = 8'h00;
    logic [15:0] REQ_LEN = 16'h0000;
    logic clr = 1'b0;
    logic slow = 1'b0;
    wire [31:0] PRDATA;
    wire [7:0] TX_DATA;
    wire PREADY, PSLVERR, REQ_DONE, REQ_STALL, TX_VALID, TX_LAST, TX_READY;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int m;
    logic [31:0] rd;
    logic st;
    row_t rows [0:4] = '{
        {32'h0000_0001, 32'h0001_0132, 8'h29, 16'h0009, 8'h03},
        {32'h0000_310a, 32'ha544_3310, 8'h00, 16'h0009, 8'h02},
        {32'h0000_3115, 32'h5a66_7708, 8'h29, 16'h000c, 8'h01},
        {32'h0000_771e, 32'h0102_0304, 8'h29, 16'h0004, 8'h00},
        {32'h0000_0701, 32'h0000_0000, 8'h00, 16'h0001, 8'h03}};
    hub_desc_builder i_hub_desc_builder (.CLK(CLK), .RST_N(RST_N),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .REQ_VALID(REQ_VALID), .REQ_TYPE(REQ_TYPE),
        .REQ_LEN(REQ_LEN), .REQ_DONE(REQ_DONE), .REQ_STALL(REQ_STALL),
        .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST),
        .TX_READY(TX_READY));
    hub_host_model i_hub_host_model (.clk(CLK), .clr(clr), .slow(slow),
        .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_ready(TX_READY));
    initial forever #5 CLK = ~CLK;
    // ====================
    // Tasks
    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
            @(posedge CLK);
        while (PREADY !== 1'b1);
        rd = PRDATA;
        st = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic req(input logic [7:0] t, logic [15:0] l, logic c);
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        REQ_TYPE <= t;
        REQ_LEN <= l;
        clr <= c;
        @(posedge CLK);
        REQ_VALID <= 1'b0;
        clr <= 1'b0;
    endtask
    task automatic fin;
        do
            @(posedge CLK);
        while (REQ_DONE !== 1'b1 && REQ_STALL !== 1'b1);
        st = REQ_STALL;
    endtask
    function automatic logic [7:0] eb(input row_t r, input int i);
        case (i)
            0: eb = 8'h09;
            1: eb = 8'h29;
            2: eb = r.np;
            3: eb = {3'h0, r.cfg[4:3], r.cfg[2], 1'b0, r.cfg[1]};
            4: eb = 8'h00;
            5: eb = r.pwr[7:0];
            6: eb = r.cfg[0] ? r.pwr[23:16] : r.pwr[15:8];
            7: eb = r.pwr[31:24];
            default: eb = 8'hff;
        endcase
    endfunction
    // ====================
    // Sequence
    initial
    begin
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0001_0132);
        apb(1'b1, 12'h000, 32'hffff_ffff);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_771f);
        apb(1'b0, 12'h00c, 32'h0);
        chk(st, 1'b1);
        for (int k = 0; k < 5; k++)
        begin
            apb(1'b1, 12'h000, rows[k].cfg);
            apb(1'b1, 12'h004, rows[k].pwr);
            apb(1'b0, 12'h008, 32'h0);
            chk(rd[7:0], rows[k].np);
            chk(rd[23:8], {8'h00, eb(rows[k], 3)});
            slow <= k[0];
            req(rows[k].typ, rows[k].len, 1'b1);
            fin();
            m = rows[k].len > 9 ? 9 : int'(rows[k].len);
            chk(i_hub_host_model.n, m);
            for (int j = 0; j < m; j++)
                chk(i_hub_host_model.got[j], eb(rows[k], j));
        end
        // Refusals: unknown type, request while busy; zero length completes with no bytes
        req(8'h22, 16'h0009, 1'b1);
        fin();
        chk(st, 1'b1);
        chk(i_hub_host_model.n, 0);
        req(8'h29, 16'h0000, 1'b1);
        fin();
        chk(st, 1'b0);
        slow <= 1'b1;
        req(8'h00, 16'h0009, 1'b1);
        repeat (2) @(posedge CLK);
        req(8'h29, 16'h0009, 1'b0);
        fin();
        chk(st, 1'b1);
        fin();
        chk(i_hub_host_model.n, 9);
        // Reset in mid-stream: byte port drops, registers go back to
        // their defaults and a fresh request streams in full
        req(8'h29, 16'h0009, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd[24], 1'b1);
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        chk(TX_VALID, 1'b0);
        chk(TX_DATA, 8'h00);
        RST_N <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0001_0132);
        req(8'h29, 16'h0009, 1'b1);
        fin();
        chk(i_hub_host_model.n, 9);
        chk(i_hub_host_model.got[2], 8'h03);
        conclude();
    end
endmodule
`default_nettype wire
